// >>> flash_if_consts.svh
// Offsets, field positions, reset values and timing counts of the flash interface
`ifndef FLASH_IF_CONSTS_SVH
`define FLASH_IF_CONSTS_SVH
`define FCS_OFFSET 16'h7000
`define FWT_OFFSET 16'h7004
`define FCS_ASYNC_BIT 7
`define FCS_DONE_BIT 4
`define FCS_IDLE_BIT 3
`define FCS_IRQ_BIT 2
`define FCS_PEN_BIT 1
`define FCS_LPM_BIT 0
`define FWT_SLEN_HI 5
`define FWT_SLEN_LO 4
`define FWT_EQD_BIT 3
`define FWT_WAIT_HI 2
`define FWT_RESERVED_BIT 6
`define FCS_RESET 8'hE0
`define FWT_RESET 8'h03
`define FCS_BOOT 8'h60
`define FWT_BOOT 8'h13
`define CLK_PERIOD_PS 5000
`define STROBE_TO_EQ_MIN_PS 10000
`define EQ_PULSE_MIN_PS 20000
`define READ_CYCLE_MIN_PS 40000
`define ACCESS_EXTRA_PS 5000
`define STROBE_TO_EQ_CYC ((`STROBE_TO_EQ_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define EQ_PULSE_CYC ((`EQ_PULSE_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_CYCLE_CYC ((`READ_CYCLE_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// >>> flash_if_pkg.sv
// Types shared by the flash interface modules
package flash_if_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_EQ, ST_WAIT, ST_SPACE
  } access_state_t;
endpackage : flash_if_pkg

// >>> half_cycle_strobe.sv
// Half-cycle resolution strobe: level on rising edge, half-cycle trim or extension on falling edge
`timescale 1ns/1ps
module half_cycle_strobe #(
  parameter bit TRIM = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control
  input wire logic rise_level,
  input wire logic half_extend,
  // Output
  output logic strobe
);
  logic rise_reg;
  logic fall_reg;

  // Rising-edge level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rise_reg <= 1'b0;
    else if (ce) rise_reg <= rise_level;
  end

  // Falling edge: trim mode marks the middle of the last high cycle, else it trails the level
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) fall_reg <= 1'b0;
    else if (ce) fall_reg <= TRIM ? (rise_reg & ~rise_level) : rise_reg;
  end

  // Trim ends the pulse half a cycle early; extension keeps it half a cycle longer
  assign strobe = TRIM ? (rise_reg & ~(fall_reg & half_extend))
                       : (rise_reg | (fall_reg & half_extend));
endmodule : half_cycle_strobe

// >>> pin_sync.sv
// Two-flip-flop synchroniser for levels from the flash array
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync

// >>> flash_read_write_interface.sv
// Flash array access controller with APB control/status and wait-control registers
//
// Summary of operation
// - Control bit 7 low: strobe-driven synchronous reads; high: asynchronous reads.
// - Done flag bit 4 sets when the automatic program/erase algorithm completes.
// - Reading the done flag returns it and then clears it.
// - Idle bit 3 reads 0 while the algorithm runs, 1 when commands accepted.
// - Program enable 0 blocks writes, 32-bit reads; 1 allows writes, 16-bit reads.
// - Program enable only changes while the idle bit is 1; the boot value load clears it even while the algorithm runs.
// - Strobe length codes 0..3 give 0.5, 1, 1.5, 2 core-clock cycles high.
// - Equalize delay bit 0 ends equalize with wait; 1 adds half a cycle.
// - Wait count field inserts 0 to 7 wait cycles into each access.
// - At least 10 ns strobe to equalize, 20 ns equalize; access within sum plus 5.
// - Each flash read cycle lasts at least 40 ns.
// - Registers reset to E0/03 and boot values 60/13 load when boot completes.
`timescale 1ns/1ps
`include "flash_if_consts.svh"
module flash_read_write_interface #(
  parameter int ADDR_W = 20
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Boot program completion, loads boot register values
  input wire logic boot_load,
  // Flash access request from the bus side
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [ADDR_W-1:0] acc_addr,
  output logic acc_done,
  output logic acc_wide,
  // Flash array
  input wire logic algo_busy,
  input wire logic algo_finished,
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_cs,
  output logic flash_we,
  output logic flash_async,
  output logic flash_low_power,
  output logic addr_transition_strobe,
  output logic equalize_strobe,
  output logic wait_request
);
  logic [7:0] fcs_reg;
  logic [7:0] fwt_reg;
  logic algo_done_flag_reg;
  logic [1:0] arr_sync;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] space_reg;
  logic finished_d_reg;
  logic [31:0] prdata_next;
  flash_if_pkg::access_state_t state_reg;
  flash_if_pkg::access_state_t state_next;
  logic [ADDR_W-1:0] faddr_reg;
  logic fcs_out_reg;
  logic fwe_reg;
  logic done_reg;
  logic wreq_reg;
  logic atd_level;
  logic eq_level;
  logic atd_raw;
  logic eq_raw;
  logic acc_write_q;

  // Array status crosses from the flash macro's own timing
  pin_sync #(.WIDTH(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in({algo_busy, algo_finished}),
    .sync_out(arr_sync)
  );

  wire busy_s = arr_sync[1];
  wire finished_s = arr_sync[0];
  wire algo_idle = ~busy_s;
  wire finish_evt = finished_s & ~finished_d_reg;

  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_access = psel & penable;
  wire hit_fcs = (paddr == `FCS_OFFSET);
  wire hit_fwt = (paddr == `FWT_OFFSET);
  wire unmapped = ~(hit_fcs | hit_fwt);
  wire wr_fcs = apb_access & pwrite & hit_fcs;
  wire wr_fwt = apb_access & pwrite & hit_fwt;
  wire rd_fcs = apb_access & ~pwrite & hit_fcs;

  // Field decode
  wire async_sel = fcs_reg[`FCS_ASYNC_BIT];
  wire program_enable = fcs_reg[`FCS_PEN_BIT];
  wire low_power_sel = fcs_reg[`FCS_LPM_BIT];
  wire [1:0] addr_strobe_len = fwt_reg[`FWT_SLEN_HI:`FWT_SLEN_LO];
  wire equalize_delay_sel = fwt_reg[`FWT_EQD_BIT];
  wire [2:0] wait_count = fwt_reg[`FWT_WAIT_HI:0];

  // Whole cycles of strobe high, rounded up; half cycle trimmed by falling edge
  function automatic logic [3:0] strobe_whole(input logic [1:0] code);
    strobe_whole = {2'b00, code[1]} + 4'h1;
  endfunction : strobe_whole

  // Longer of a configured count and a timing floor
  function automatic logic [3:0] at_least(input logic [3:0] a, input logic [3:0] b);
    at_least = (a > b) ? a : b;
  endfunction : at_least

  // Status read image; reserved bits 6 and 5 read as stored
  assign prdata_next = hit_fcs ? {24'h0, fcs_reg[7:5], algo_done_flag_reg, algo_idle,
                                  fcs_reg[2:0]}
                     : hit_fwt ? {24'h0, fwt_reg} : 32'h0;

  // Control register; program enable writable only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcs_reg <= `FCS_RESET;
    end else if (ce) begin
      if (boot_load) begin
        fcs_reg <= `FCS_BOOT;
      end else if (wr_fcs) begin
        fcs_reg[7:5] <= pwdata[7:5];
        fcs_reg[`FCS_IRQ_BIT] <= pwdata[`FCS_IRQ_BIT];
        fcs_reg[`FCS_LPM_BIT] <= pwdata[`FCS_LPM_BIT];
        if (algo_idle) begin
          fcs_reg[`FCS_PEN_BIT] <= pwdata[`FCS_PEN_BIT];
        end
      end
    end
  end

  // Wait-control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwt_reg <= `FWT_RESET;
    end else if (ce) begin
      if (boot_load) begin
        fwt_reg <= `FWT_BOOT;
      end else if (wr_fwt) begin
        fwt_reg <= {1'b0, pwdata[6:0]};
      end
    end
  end

  // Done flag: a completion in the same cycle as the clearing read wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      algo_done_flag_reg <= 1'b0;
      finished_d_reg <= 1'b0;
    end else if (ce) begin
      finished_d_reg <= finished_s;
      if (finish_evt) begin
        algo_done_flag_reg <= 1'b1;
      end else if (rd_fcs) begin
        algo_done_flag_reg <= 1'b0;
      end
    end
  end

  // APB answer: no wait states, ready and data registered in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= apb_setup;
      pslverr <= apb_setup & unmapped;
      if (apb_setup & ~pwrite) begin
        prdata <= prdata_next;
      end
    end
  end

  // Access sequencer
  wire write_ok = acc_write & program_enable & algo_idle;
  // The request is still up in the cycle its done pulse shows; do not restart on it
  wire start = acc_req & ~done_reg & (~acc_write | write_ok);
  wire [3:0] atd_cyc = async_sel ? 4'h1 : strobe_whole(addr_strobe_len);
  wire [3:0] eq_cyc = 4'(`EQ_PULSE_CYC);
  wire [3:0] atd_min = at_least(atd_cyc, 4'(`STROBE_TO_EQ_CYC));
  wire [3:0] total = atd_min + eq_cyc + {1'b0, wait_count};
  wire [3:0] space_cyc = (total >= 4'(`READ_CYCLE_CYC)) ? 4'h0
                         : 4'(`READ_CYCLE_CYC) - total;
  wire cnt_last = (cnt_reg == 4'h1);

  // Next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
    unique case (state_reg)
      flash_if_pkg::ST_IDLE: begin
        if (start) begin
          state_next = flash_if_pkg::ST_ADDR;
          cnt_next = atd_min;
        end
      end
      flash_if_pkg::ST_ADDR: begin
        if (cnt_last) begin
          state_next = flash_if_pkg::ST_EQ;
          cnt_next = eq_cyc;
        end
      end
      flash_if_pkg::ST_EQ: begin
        if (cnt_last) begin
          state_next = (wait_count == 3'h0) ? flash_if_pkg::ST_SPACE
                                            : flash_if_pkg::ST_WAIT;
          cnt_next = (wait_count == 3'h0) ? space_reg : {1'b0, wait_count};
        end
      end
      flash_if_pkg::ST_WAIT: begin
        if (cnt_last) begin
          state_next = flash_if_pkg::ST_SPACE;
          cnt_next = space_reg;
        end
      end
      flash_if_pkg::ST_SPACE: begin
        if (cnt_reg <= 4'h1) begin
          state_next = flash_if_pkg::ST_IDLE;
          cnt_next = 4'h0;
        end
      end
      default: begin
        state_next = flash_if_pkg::ST_IDLE;
      end
    endcase
  end

  // Strobe levels; asynchronous mode keeps strobes low
  // Address strobe covers only the first whole cycles of the address phase
  assign atd_level = ~async_sel & (state_next == flash_if_pkg::ST_ADDR)
                     & ((state_reg == flash_if_pkg::ST_IDLE)
                        | ((cnt_reg + atd_cyc) > (atd_min + 4'h1)));
  assign eq_level = ~async_sel & ~acc_write_q &
                    ((state_next == flash_if_pkg::ST_EQ) | (state_next == flash_if_pkg::ST_WAIT));

  // Sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= flash_if_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      space_reg <= 4'h0;
      faddr_reg <= '0;
      fcs_out_reg <= 1'b0;
      fwe_reg <= 1'b0;
      done_reg <= 1'b0;
      wreq_reg <= 1'b0;
      acc_write_q <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= (state_reg != flash_if_pkg::ST_IDLE) &
                  (state_next == flash_if_pkg::ST_IDLE);
      wreq_reg <= (state_next == flash_if_pkg::ST_WAIT);
      fcs_out_reg <= (state_next != flash_if_pkg::ST_IDLE) &
                     (state_next != flash_if_pkg::ST_SPACE);
      if ((state_reg == flash_if_pkg::ST_IDLE) & start) begin
        faddr_reg <= acc_addr;
        fwe_reg <= acc_write;
        acc_write_q <= acc_write;
        space_reg <= space_cyc;
      end
    end
  end

  // Half-cycle trim for even strobe codes, half-cycle extension for the equalize delay option
  half_cycle_strobe #(.TRIM(1'b1)) u_atd (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rise_level(atd_level),
    .half_extend(~addr_strobe_len[0]),
    .strobe(atd_raw)
  );
  half_cycle_strobe u_eq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .rise_level(eq_level),
    .half_extend(equalize_delay_sel),
    .strobe(eq_raw)
  );

  // Strobes combine a rising- and a falling-edge flop; one flop cannot give half-cycle widths
  assign addr_transition_strobe = atd_raw;
  assign equalize_strobe = eq_raw;
  assign wait_request = wreq_reg;
  assign flash_addr = faddr_reg;
  assign flash_cs = fcs_out_reg;
  assign flash_we = fwe_reg & fcs_out_reg;
  assign flash_async = fcs_reg[`FCS_ASYNC_BIT];
  assign flash_low_power = fcs_reg[`FCS_LPM_BIT];
  assign acc_wide = ~fcs_reg[`FCS_PEN_BIT];
  assign acc_done = done_reg;
endmodule : flash_read_write_interface

// >>> flash_rw_monitor.sv
// Port-level assertions for the flash read/write interface
`timescale 1ns/1ps
module flash_rw_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Access side and array
  input wire logic acc_req,
  input wire logic acc_done,
  input wire logic acc_wide,
  input wire logic algo_busy,
  input wire logic flash_we,
  input wire logic addr_transition_strobe,
  input wire logic equalize_strobe,
  input wire logic wait_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] wait_run_reg;
  // Run length of wait cycles; a stuck wait overruns the 3-bit count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wait_run_reg <= 4'h0;
    else wait_run_reg <= wait_request ? wait_run_reg + 4'h1 : 4'h0;
  end
  a_pready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("no pready after setup");
  a_we_needs_pen: assert property (flash_we |-> !acc_wide)
    else $error("write while program enable low");
  a_pen_frozen_busy: assert property (algo_busy [*4] |-> ##1 $stable(acc_wide))
    else $error("program enable changed while busy");
  a_read_cycle_min: assert property ($rose(acc_req) |-> !acc_done [*7])
    else $error("access shorter than 8 cycles");
  a_access_bounded: assert property ($rose(acc_req) |-> ##[1:80] acc_done)
    else $error("access never completed");
  a_strobe_len: assert property ($rose(addr_transition_strobe) |-> ##2 !addr_transition_strobe)
    else $error("address strobe too long");
  a_eq_pulse: assert property ($rose(equalize_strobe) |-> equalize_strobe [*3])
    else $error("equalize pulse too short");
  a_eq_release: assert property ($fell(wait_request) |-> ##[0:2] !equalize_strobe)
    else $error("equalize not released after wait");
  a_wait_run: assert property (wait_run_reg <= 4'h7)
    else $error("more than 7 wait cycles");
endmodule : flash_rw_monitor
bind flash_read_write_interface flash_rw_monitor flash_rw_monitor_inst (.pclk, .presetn, .ce,
  .psel, .penable, .pready, .acc_req, .acc_done, .acc_wide, .algo_busy, .flash_we,
  .addr_transition_strobe, .equalize_strobe, .wait_request);

// >>> flash_array_model.sv
// Behavioural flash array: runs its automatic algorithm after each write strobe that rises while it is idle
`timescale 1ns/1ps
module flash_array_model #(
  parameter int BUSY_CYC = 60
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Array side
  input wire logic flash_we,
  output logic algo_busy,
  output logic algo_finished
);
  logic we_reg;
  int cnt_reg;
  // Busy for a fixed span, then finished stays high until the next start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_reg <= 1'b0;
      cnt_reg <= 0;
      algo_busy <= 1'b0;
      algo_finished <= 1'b0;
    end else begin
      we_reg <= flash_we;
      if (flash_we && !we_reg && !algo_busy) begin
        algo_busy <= 1'b1;
        algo_finished <= 1'b0;
        cnt_reg <= BUSY_CYC;
      end else if (algo_busy) begin
        cnt_reg <= cnt_reg - 1;
        if (cnt_reg == 1) begin
          algo_busy <= 1'b0;
          algo_finished <= 1'b1;
        end
      end
    end
  end
endmodule : flash_array_model

// >>> tb.sv
// Self-checking bench for the flash read/write interface
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, ce, psel, penable, pwrite, boot_load, acc_req, acc_write;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err, acc_done, acc_wide, algo_busy, algo_finished;
  logic [19:0] acc_addr, flash_addr;
  logic flash_cs, flash_we, flash_async, flash_low_power;
  logic addr_transition_strobe, equalize_strobe, wait_request;
  int n_fail = 0;
  int num_checks = 0;
  int waits, cyc, atd_ps, eq_ps;
  realtime atd_t, eq_t;

  flash_read_write_interface flash_read_write_interface_inst (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .boot_load, .acc_req,
    .acc_write, .acc_addr, .acc_done, .acc_wide, .algo_busy, .algo_finished, .flash_addr,
    .flash_cs, .flash_we, .flash_async, .flash_low_power, .addr_transition_strobe,
    .equalize_strobe, .wait_request);
  flash_array_model flash_array_model_inst (.pclk, .presetn, .flash_we, .algo_busy,
    .algo_finished);

  // Strobe high times in ps; half-cycle widths need both edges of the strobe
  always @(posedge addr_transition_strobe) atd_t = $realtime;
  always @(negedge addr_transition_strobe) atd_ps = int'(($realtime - atd_t) * 1000.0);
  always @(posedge equalize_strobe) eq_t = $realtime;
  always @(negedge equalize_strobe) eq_ps = int'(($realtime - eq_t) * 1000.0);

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk

  // One APB transfer; holds the request until pready, then an idle edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // One flash access; request held until done, counts wait cycles seen
  task automatic acc(input logic wr);
    waits = 0;
    cyc = 0;
    acc_req <= 1'b1;
    acc_write <= wr;
    do begin
      @(posedge pclk);
      cyc++;
      if (wait_request === 1'b1) waits++;
    end while (acc_done !== 1'b1 && cyc < 100);
    chk(32'h1, {31'h0, acc_done});
    chk({12'h0, acc_addr}, {12'h0, flash_addr});
    acc_req <= 1'b0;
    acc_write <= 1'b0;
    @(posedge pclk);
  endtask : acc

  task automatic t_reset();
    chk(32'h3, {30'h0, acc_wide, flash_async});
    apb(1'b0, 16'h7000, 32'h0);
    chk(32'hE8, rd);
    apb(1'b0, 16'h7004, 32'h0);
    chk(32'h03, rd);
    apb(1'b0, 16'h7008, 32'h0);
    chk(32'h1, {31'h0, err});
    chk(32'h0, rd);
  endtask : t_reset

  task automatic t_boot();
    boot_load <= 1'b1;
    @(posedge pclk);
    boot_load <= 1'b0;
    @(posedge pclk);
    apb(1'b0, 16'h7000, 32'h0);
    chk(32'h68, rd);
    apb(1'b0, 16'h7004, 32'h0);
    chk(32'h13, rd);
  endtask : t_boot

  task automatic t_ctrl();
    apb(1'b1, 16'h7000, 32'h61);
    chk(32'h1, {30'h0, flash_async, flash_low_power});
    apb(1'b0, 16'h7000, 32'h0);
    chk(32'h69, rd);
    apb(1'b1, 16'h7000, 32'hE0);
    chk(32'h2, {30'h0, flash_async, flash_low_power});
  endtask : t_ctrl

  // Every wait count, strobe length and equalize delay in synchronous mode
  task automatic t_access();
    logic [7:0] v;
    apb(1'b1, 16'h7000, 32'h60);
    for (int i = 0; i < 8; i++) begin
      v = {2'b00, i[1:0], i[0], i[2:0]};
      apb(1'b1, 16'h7004, {24'h0, v});
      apb(1'b0, 16'h7004, 32'h0);
      chk({24'h0, v}, rd);
      acc(1'b0);
      chk(i, waits);
      chk(32'h1, {31'h0, cyc >= 8});
      chk((i % 4 + 1) * 2500, atd_ps);
      chk((4 + i) * 5000 + (i % 2) * 2500, eq_ps);
    end
    apb(1'b1, 16'h7004, 32'h09);
    acc(1'b0);
    chk(1, waits);
    chk(2500, atd_ps);
  endtask : t_access

  // Program, try to drop enable mid-algorithm, then collect the done flag
  task automatic t_prog();
    int n;
    n = 0;
    apb(1'b1, 16'h7000, 32'hE2);
    chk(32'h0, {31'h0, acc_wide});
    apb(1'b1, 16'h7004, 32'h02);
    acc(1'b1);
    apb(1'b1, 16'h7000, 32'hE0);
    apb(1'b0, 16'h7000, 32'h0);
    chk(32'hE2, rd);
    while (algo_finished !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) n_fail++;
    repeat (4) @(posedge pclk);
    apb(1'b0, 16'h7000, 32'h0);
    chk(32'hFA, rd);
    apb(1'b0, 16'h7000, 32'h0);
    chk(32'hEA, rd);
    apb(1'b1, 16'h7000, 32'hE0);
    chk(32'h1, {31'h0, acc_wide});
  endtask : t_prog

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    boot_load = 1'b0;
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_addr = 20'h00010;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_boot();
    t_ctrl();
    t_access();
    t_prog();
    tally_and_finish();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb
